// File: qu_pkg.sv
/*
  Shared constants and types for the four-channel serial transceiver.
  Assumes one 125 MHz system clock and an oscillator pin that runs well
  below a quarter of that rate.
*/
package qu_pkg;

  // channel count and character shape
  localparam int CHANNELS   = 4;
  localparam int CHAR_BITS  = 8;
  localparam int FIFO_DEPTH = 4;

  // system clock period in ns (125 MHz)
  localparam int CLK_PERIOD_NS = 8;

  // oversampling: sixteen oscillator rising edges per bit, sampled at the middle
  localparam logic [3:0] PHASE_LAST = 4'hF;
  localparam logic [3:0] PHASE_MID  = 4'h7;

  // frame: start, eight data bits, stop
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [2:0] DATA_LAST  = 3'h7;
  localparam logic       START_BIT  = 1'b0;
  localparam logic       STOP_BIT   = 1'b1;

  // line and flag levels after reset
  localparam logic [3:0] LINE_IDLE  = 4'hF;
  localparam logic       READY_OFF  = 1'b1;

  // one byte lane per channel
  typedef logic [CHANNELS-1:0][CHAR_BITS-1:0] qu_lanes_t;

  // per-channel status flags
  typedef struct packed {
    logic [CHANNELS-1:0] rx_ready;
    logic [CHANNELS-1:0] tx_ready;
  } qu_status_t;

  // receiver sequence, one-hot
  typedef enum logic [3:0] {
    QU_RX_IDLE  = 4'h1,
    QU_RX_START = 4'h2,
    QU_RX_DATA  = 4'h4,
    QU_RX_STOP  = 4'h8
  } qu_rx_state_t;

endpackage : qu_pkg

// File: qu_top.sv
/*
  Four-channel serial transceiver core with a transmit FIFO per channel,
  a receive holding register per channel, local loop-back and combined
  active-low ready outputs.
  Assumes the host logic runs on clk_sys; the serial inputs and the
  oscillator pin are asynchronous and are synchronised here.
*/
// Summary of operation
// - transmit pin stays high in reset, when idle, and when disabled
// - loop-back disables transmit pin and feeds transmit data to receiver
// - loop-back ignores the external receive input
// - one active-low receive-ready output ORs all four channels
// - receive-ready goes low when any channel holds a character
// - receive-ready returns high when no character remains anywhere
// - one active-low transmit-ready output ORs all four channels
// - transmit-ready low while any channel has a free location
// - transmit-ready high only in reset or when all channels are full
// - each channel's own receive readiness is visible to the host
// - each channel's own transmit readiness is visible to the host
// - bit timing comes from oscillator input; buffered copy driven out
// - reset clears all state and forces outputs to reset levels
`timescale 1ns/100ps
`default_nettype none

module qu_fifo
  import qu_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,   // system clock
  input  wire logic             reset_n,   // async reset, active low
  input  wire logic             in_valid,  // writer offers a word
  input  wire logic [WIDTH-1:0] in_data,   // word offered
  output var  logic             in_ready,  // a free location exists
  output var  logic             out_valid, // a word is waiting
  output var  logic [WIDTH-1:0] out_data,  // oldest word
  input  wire logic             out_ready  // reader takes the word
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_LAST  = AW'(DEPTH - 1);
  localparam logic [AW:0]   CNT_FULL  = (AW + 1)'(DEPTH);
  localparam logic [AW:0]   CNT_ONE   = (AW + 1)'(1);
  localparam logic [AW-1:0] PTR_ONE   = AW'(1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
    logic                        in_rdy;
    logic                        out_vld;
  } qu_fifo_state_t;

  // empty after reset, so writes are accepted at once
  localparam qu_fifo_state_t FIFO_RESET = '{
    mem:     '0,
    wr_ptr:  '0,
    rd_ptr:  '0,
    count:   '0,
    in_rdy:  1'b1,
    out_vld: 1'b0
  };

  qu_fifo_state_t st;
  qu_fifo_state_t next_st;

  // flags held in flops so the ports carry no logic
  assign in_ready  = st.in_rdy;
  assign out_valid = st.out_vld;
  assign out_data  = st.mem[st.rd_ptr];

  // pointer and count update; push and pop may share a cycle
  always_comb begin
    logic push;
    logic pop;
    push    = in_valid & st.in_rdy;
    pop     = st.out_vld & out_ready;
    next_st = st;
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data;
      next_st.wr_ptr = (st.wr_ptr == PTR_LAST) ? '0 : st.wr_ptr + PTR_ONE;
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == PTR_LAST) ? '0 : st.rd_ptr + PTR_ONE;
    end
    if (push && !pop) begin
      next_st.count = st.count + CNT_ONE;
    end else if (pop && !push) begin
      next_st.count = st.count - CNT_ONE;
    end
    next_st.in_rdy  = (next_st.count != CNT_FULL);
    next_st.out_vld = (next_st.count != '0);
  end

  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= FIFO_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule : qu_fifo

module qu_top
  import qu_pkg::*;
(
  input  wire logic                clk_sys,                    // 125 MHz
  input  wire logic                reset_n,                    // async
  input  wire logic                oscillator_input,           // bit clock
  output var  logic                oscillator_output,          // buffered
  input  wire logic [CHANNELS-1:0] serial_receive_inputs,      // rx pins
  output var  logic [CHANNELS-1:0] serial_transmit_outputs,    // tx pins
  input  wire logic [CHANNELS-1:0] loopback_enable,            // per chan
  input  wire logic [CHANNELS-1:0] transmitter_enable,         // per chan
  input  wire logic [CHANNELS-1:0] host_tx_valid,              // write
  input  wire qu_lanes_t           host_tx_data,               // tx chars
  output var  logic [CHANNELS-1:0] per_channel_transmit_ready, // room
  input  wire logic [CHANNELS-1:0] host_rx_read,               // read
  output var  qu_lanes_t           host_rx_data,               // rx chars
  output var  logic [CHANNELS-1:0] per_channel_receive_ready,  // char held
  output var  logic                combined_receive_ready_n,   // any rx
  output var  logic                combined_transmit_ready_n   // any room
);

  typedef struct packed {
    logic [1:0]                           osc_sync;
    logic                                 osc_prev;
    logic                                 osc_out;
    logic [CHANNELS-1:0]                  rx_meta;
    logic [CHANNELS-1:0]                  rx_sync;
    logic [CHANNELS-1:0]                  tx_busy;
    logic [CHANNELS-1:0][9:0]             tx_shift;
    logic [CHANNELS-1:0][3:0]             tx_bitcnt;
    logic [CHANNELS-1:0][3:0]             tx_phase;
    logic [CHANNELS-1:0]                  tx_pin;
    qu_rx_state_t [CHANNELS-1:0]          rx_state;
    logic [CHANNELS-1:0][3:0]             rx_phase;
    logic [CHANNELS-1:0][2:0]             rx_cnt;
    logic [CHANNELS-1:0][CHAR_BITS-1:0]   rx_shift;
    logic [CHANNELS-1:0][CHAR_BITS-1:0]   rx_hold;
    logic [CHANNELS-1:0]                  rx_full;
    logic                                 rx_rdy_n;
    logic                                 tx_rdy_n;
  } qu_state_t;

  localparam qu_state_t TOP_RESET = '{
    osc_sync:  '0,
    osc_prev:  1'b0,
    osc_out:   1'b0,
    rx_meta:   LINE_IDLE,
    rx_sync:   LINE_IDLE,
    tx_busy:   '0,
    tx_shift:  '0,
    tx_bitcnt: '0,
    tx_phase:  '0,
    tx_pin:    LINE_IDLE,
    rx_state:  '{default: QU_RX_IDLE},
    rx_phase:  '0,
    rx_cnt:    '0,
    rx_shift:  '0,
    rx_hold:   '0,
    rx_full:   '0,
    rx_rdy_n:  READY_OFF,
    tx_rdy_n:  READY_OFF
  };

  qu_state_t st;
  qu_state_t next_st;

  logic [CHANNELS-1:0] fifo_ready;
  logic [CHANNELS-1:0] fifo_valid;
  qu_lanes_t           fifo_data;
  logic [CHANNELS-1:0] tx_pop;

  // one transmit FIFO per channel; a full FIFO stalls the host writer
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      qu_fifo #(
        .WIDTH (CHAR_BITS),
        .DEPTH (FIFO_DEPTH)
      ) u_tx_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_valid  (host_tx_valid[g]),
        .in_data   (host_tx_data[g]),
        .in_ready  (fifo_ready[g]),
        .out_valid (fifo_valid[g]),
        .out_data  (fifo_data[g]),
        .out_ready (tx_pop[g])
      );
    end
  endgenerate

  // own transmit readiness, straight from the FIFO flag flop
  assign per_channel_transmit_ready = fifo_ready;
  assign per_channel_receive_ready  = st.rx_full;
  assign host_rx_data               = st.rx_hold;
  assign serial_transmit_outputs    = st.tx_pin;
  assign oscillator_output          = st.osc_out;
  assign combined_receive_ready_n   = st.rx_rdy_n;
  assign combined_transmit_ready_n  = st.tx_rdy_n;

  // next-state logic for all four channels
  always_comb begin
    logic tick;
    logic tx_line;
    logic rx_line;
    tick    = 1'b0;
    tx_line = 1'b1;
    rx_line = 1'b1;
    next_st = st;
    tx_pop  = '0;

    // oscillator pin synchronised; its rising edge paces all bits
    next_st.osc_sync = {st.osc_sync[0], oscillator_input};
    next_st.osc_prev = st.osc_sync[1];
    // buffered copy, three clocks behind the pin
    next_st.osc_out  = st.osc_sync[1];
    tick = st.osc_sync[1] & ~st.osc_prev;

    // serial inputs pass two flops before anything reads them
    next_st.rx_meta = serial_receive_inputs;
    next_st.rx_sync = st.rx_meta;

    for (int c = 0; c < CHANNELS; c++) begin
      // line level the transmitter produces, before any gating
      tx_line = st.tx_busy[c] ? st.tx_shift[c][0] : STOP_BIT;

      // transmitter: a disabled channel leaves its FIFO untouched
      if (!st.tx_busy[c]) begin
        if (fifo_valid[c] && transmitter_enable[c]) begin
          tx_pop[c]            = 1'b1;
          next_st.tx_shift[c]  = {STOP_BIT, fifo_data[c], START_BIT};
          next_st.tx_busy[c]   = 1'b1;
          next_st.tx_bitcnt[c] = '0;
          next_st.tx_phase[c]  = '0;
        end
      end else if (tick) begin
        next_st.tx_phase[c] = st.tx_phase[c] + 4'h1;
        if (st.tx_phase[c] == PHASE_LAST) begin
          next_st.tx_shift[c] = {STOP_BIT, st.tx_shift[c][9:1]};
          if (st.tx_bitcnt[c] == FRAME_LAST) begin
            next_st.tx_busy[c] = 1'b0;
          end else begin
            next_st.tx_bitcnt[c] = st.tx_bitcnt[c] + 4'h1;
          end
        end
      end

      // pin high when idle or disabled
      // loop-back takes the pin out of use
      if (transmitter_enable[c] && !loopback_enable[c] &&
          next_st.tx_busy[c]) begin
        next_st.tx_pin[c] = next_st.tx_shift[c][0];
      end else begin
        next_st.tx_pin[c] = STOP_BIT;
      end

      rx_line = loopback_enable[c] ? tx_line : st.rx_sync[c];

      // host read clears the flag; a store below wins over it
      if (host_rx_read[c]) begin
        next_st.rx_full[c] = 1'b0;
      end

      // receiver: mid-bit sampling, false starts dropped
      case (st.rx_state[c])
        QU_RX_IDLE: begin
          if (!rx_line) begin
            next_st.rx_state[c] = QU_RX_START;
            next_st.rx_phase[c] = '0;
          end
        end
        QU_RX_START: begin
          if (tick) begin
            next_st.rx_phase[c] = st.rx_phase[c] + 4'h1;
            if (st.rx_phase[c] == PHASE_MID) begin
              if (rx_line) begin
                next_st.rx_state[c] = QU_RX_IDLE;
              end else begin
                next_st.rx_state[c] = QU_RX_DATA;
                next_st.rx_phase[c] = '0;
                next_st.rx_cnt[c]   = '0;
              end
            end
          end
        end
        QU_RX_DATA: begin
          if (tick) begin
            next_st.rx_phase[c] = st.rx_phase[c] + 4'h1;
            if (st.rx_phase[c] == PHASE_LAST) begin
              next_st.rx_shift[c] = {rx_line,
                                     st.rx_shift[c][CHAR_BITS-1:1]};
              next_st.rx_cnt[c]   = st.rx_cnt[c] + 3'h1;
              if (st.rx_cnt[c] == DATA_LAST) begin
                next_st.rx_state[c] = QU_RX_STOP;
              end
            end
          end
        end
        QU_RX_STOP: begin
          if (tick) begin
            next_st.rx_phase[c] = st.rx_phase[c] + 4'h1;
            if (st.rx_phase[c] == PHASE_LAST) begin
              next_st.rx_state[c] = QU_RX_IDLE;
              // a bad stop bit drops the character; overrun overwrites
              if (rx_line) begin
                next_st.rx_hold[c] = st.rx_shift[c];
                next_st.rx_full[c] = 1'b1;
              end
            end
          end
        end
        default: begin
          next_st.rx_state[c] = QU_RX_IDLE;
        end
      endcase
    end

    // low while any character is held
    // follows one clock behind the flags
    next_st.rx_rdy_n = ~|st.rx_full;
    // low while any FIFO has room
    // high only in reset or when all are full
    next_st.tx_rdy_n = ~|fifo_ready;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= TOP_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule : qu_top

`default_nettype wire

// File: qu_top_asserts.sv
/*
  Port checker for the four-channel serial transceiver core.
  Assumes the bind below and an oscillator pin far slower than clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none

module qu_top_asserts
  import qu_pkg::*;
(
  input wire logic                clk_sys,                    // clock
  input wire logic                reset_n,                    // async
  input wire logic                oscillator_input,           // bit clock
  input wire logic                oscillator_output,          // copy
  input wire logic [CHANNELS-1:0] serial_transmit_outputs,    // tx pins
  input wire logic [CHANNELS-1:0] loopback_enable,            // loop
  input wire logic [CHANNELS-1:0] transmitter_enable,         // enable
  input wire logic [CHANNELS-1:0] host_tx_valid,              // write
  input wire logic [CHANNELS-1:0] per_channel_transmit_ready, // room
  input wire logic [CHANNELS-1:0] host_rx_read,               // read
  input wire qu_lanes_t           host_rx_data,               // chars
  input wire logic [CHANNELS-1:0] per_channel_receive_ready,  // held
  input wire logic                combined_receive_ready_n,   // any rx
  input wire logic                combined_transmit_ready_n   // any room
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // edges seen with reset low, saturating at two; keeps the reset check
  // away from the first edge, where the core may not be cleared yet
  logic [1:0] rst_age = 2'h0;
  always_ff @(posedge clk_sys) begin
    if (reset_n) begin
      rst_age <= 2'h0;
    end else if (rst_age != 2'h2) begin
      rst_age <= rst_age + 2'h1;
    end
  end

  // the copy follows each rising oscillator edge within a few clocks
  sequence osc_edge_s;
    $rose(oscillator_input);
  endsequence
  sequence osc_copy_s;
    ##[1:4] $rose(oscillator_output);
  endsequence
  a_osc_buffer_copy: assert property (osc_edge_s |-> osc_copy_s)
    else $error("oscillator copy missing");

  // reset output levels; held reset must not be disabled here
  a_reset_out_levels: assert property (disable iff (1'b0)
    !reset_n && rst_age == 2'h2 |-> serial_transmit_outputs == LINE_IDLE
      && combined_receive_ready_n && combined_transmit_ready_n
      && per_channel_receive_ready == '0)
    else $error("outputs not at reset levels");

  // combined receive flag, one clock lag; first edge out of reset
  // still shows the reset level
  a_rx_comb_or: assert property ($past(reset_n) |->
    combined_receive_ready_n == !(|$past(per_channel_receive_ready)))
    else $error("combined receive flag wrong");

  // combined transmit flag, one clock lag; it leaves its reset
  // level only at the first edge after release
  a_tx_comb_or: assert property ($past(reset_n) |->
    combined_transmit_ready_n == !(|$past(per_channel_transmit_ready)))
    else $error("combined transmit flag wrong");

  // disabled transmitter keeps its pin high
  a_tx_disabled_high: assert property ((~transmitter_enable
    & ~$past(transmitter_enable) & ~serial_transmit_outputs) == '0)
    else $error("disabled pin not high");

  // loop-back keeps the external pin high; two deep for skew
  a_loop_pin_high: assert property ((loopback_enable
    & $past(loopback_enable) & $past(loopback_enable, 2)
    & ~serial_transmit_outputs) == '0)
    else $error("looped pin not high");

  // read clears the flag unless a new char lands at once
  a_rx_read_clear: assert property (
    (host_rx_read & per_channel_receive_ready) != '0 |=>
      ((per_channel_receive_ready & $past(host_rx_read)) == '0)
      || $changed(host_rx_data))
    else $error("read did not clear flag");

  // a channel loses room only after a taken write
  a_tx_room_fall: assert property (($past(per_channel_transmit_ready)
    & ~per_channel_transmit_ready & ~$past(host_tx_valid)) == '0)
    else $error("room lost without a write");
endmodule : qu_top_asserts

bind qu_top qu_top_asserts u_asserts (.clk_sys, .reset_n, .oscillator_input,
  .oscillator_output, .serial_transmit_outputs, .loopback_enable,
  .transmitter_enable, .host_tx_valid, .per_channel_transmit_ready,
  .host_rx_read, .host_rx_data, .per_channel_receive_ready,
  .combined_receive_ready_n, .combined_transmit_ready_n);

`default_nettype wire

// File: qu_far_end.sv
/*
  Far-end serial source driving the four receive pins.
  Assumes sixteen oscillator rising edges make one bit.
*/
`timescale 1ns/100ps
`default_nettype none

module qu_far_end
  import qu_pkg::*;
(
  input  wire logic                 osc,     // bit clock pin
  input  wire logic                 go,      // rising edge starts a frame
  input  wire logic [1:0]           sel,     // channel carried
  input  wire logic [CHAR_BITS-1:0] char_in, // character to send
  output var  logic [CHANNELS-1:0]  lines,   // receive pins
  output var  logic                 busy     // frame in flight
);
  logic [9:0] frame;

  // idle and unused lines held high; one process owns the lines
  // start, data lsb first, stop; no retrigger while busy
  initial begin
    lines = LINE_IDLE;
    busy  = 1'b0;
    forever begin
      @(posedge go);
      busy  = 1'b1;
      frame = {STOP_BIT, char_in, START_BIT};
      for (int i = 0; i < 10; i++) begin
        lines[sel] = frame[i];
        repeat (16) @(posedge osc);
      end
      lines = LINE_IDLE;
      busy  = 1'b0;
    end
  end
endmodule : qu_far_end

`default_nettype wire

// File: quad_uart_serial_pins_ready_flags_tb_top.sv
/*
  Self-checking bench for the serial pins and combined ready flags.
  Assumes the checker is bound to qu_top and the far-end source model.
*/
`timescale 1ns/100ps
`default_nettype none

module quad_uart_serial_pins_ready_flags_tb_top
  import qu_pkg::*;
;
  logic                clk_sys = 1'b0;
  logic                reset_n = 1'b0;
  logic                osc = 1'b0;
  logic [CHANNELS-1:0] en, lb, txv, rd, tx_ready, rx_ready, tx_pins, lines;
  qu_lanes_t           txd, rx_data;
  logic                rx_comb_n, tx_comb_n, go, osc_copy;
  logic [1:0]          sel;
  logic [7:0]          ch;
  int                  fail_count = 0;
  int                  checks = 0;

  // oscillator period of eight system clocks keeps frames short
  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  always #32 osc = ~osc;

  qu_top dut (.clk_sys, .reset_n, .oscillator_input(osc),
    .oscillator_output(osc_copy), .serial_receive_inputs(lines),
    .serial_transmit_outputs(tx_pins), .loopback_enable(lb),
    .transmitter_enable(en), .host_tx_valid(txv), .host_tx_data(txd),
    .per_channel_transmit_ready(tx_ready), .host_rx_read(rd),
    .host_rx_data(rx_data), .per_channel_receive_ready(rx_ready),
    .combined_receive_ready_n(rx_comb_n),
    .combined_transmit_ready_n(tx_comb_n));

  qu_far_end far (.osc, .go, .sel, .char_in(ch), .lines, .busy());

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask : check

  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic do_reset();
    @(negedge clk_sys);
    reset_n = 1'b0;
    repeat (20) @(negedge clk_sys);
    check(tx_pins, LINE_IDLE, "tx pins in reset");
    check({rx_comb_n, tx_comb_n, osc_copy, rx_ready}, 7'h60,
          "flags in reset");
    reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(tx_comb_n, 1'b0, "no room after reset");
  endtask : do_reset

  // disabled transmitters never drain, so each fifo fills and refuses
  task automatic t_fill_block();
    for (int c = 0; c < CHANNELS; c++) begin
      check(tx_comb_n, 1'b0, "room still left");
      txv[c] = 1'b1;
      txd[c] = 8'h10 + 8'(c);
      repeat (6) @(negedge clk_sys);
      txv[c] = 1'b0;
      check(tx_ready, 4'(4'hF << (c + 1)), "channel not full");
    end
    repeat (2) @(negedge clk_sys);
    check(tx_comb_n, 1'b1, "full yet room shown");
    check(tx_pins, LINE_IDLE, "disabled pin moved");
  endtask : t_fill_block

  // wait for a char, then read it and watch both flags clear
  task automatic rx_expect(input int c, input logic [7:0] exp);
    for (int i = 0; i < 3000 && rx_ready[c] !== 1'b1; i++)
      @(negedge clk_sys);
    check(rx_data[c], exp, "received char");
    @(negedge clk_sys);
    check(rx_comb_n, 1'b0, "combined rx not low");
    rd[c] = 1'b1;
    @(negedge clk_sys);
    rd[c] = 1'b0;
    check(rx_ready, 4'h0, "read left flag");
    @(negedge clk_sys);
    check(rx_comb_n, 1'b1, "combined rx not high");
  endtask : rx_expect

  task automatic t_ext_receive();
    en = 4'hF;
    sel = 2'h2;
    ch = 8'hA5;
    go = 1'b1;
    @(negedge clk_sys);
    go = 1'b0;
    check(tx_pins, LINE_IDLE, "idle pin not high");
    rx_expect(2, 8'hA5);
  endtask : t_ext_receive

  // sample each bit of the frame near its middle; channel 0 starts a
  // zero character too, then loses its enable, so its pin must go high
  task automatic t_tx_frame();
    logic [9:0] frame;
    frame = {STOP_BIT, 8'h96, START_BIT};
    txv = 4'h9;
    txd[3] = 8'h96;
    txd[0] = 8'h00;
    @(negedge clk_sys);
    txv = 4'h0;
    for (int i = 0; i < 300 && tx_pins[3] !== 1'b0; i++)
      @(negedge clk_sys);
    en[0] = 1'b0;
    repeat (64) @(negedge clk_sys);
    check(tx_pins[0], 1'b1, "disabled pin low mid-frame");
    for (int b = 0; b < 10; b++) begin
      check(tx_pins[3], frame[b], "tx frame bit");
      repeat (128) @(negedge clk_sys);
    end
    en[0] = 1'b1;
  endtask : t_tx_frame

  // far end sends a different char on the looped channel meanwhile
  task automatic t_loopback();
    lb[1] = 1'b1;
    repeat (2) @(negedge clk_sys);
    sel = 2'h1;
    ch = 8'h0F;
    go = 1'b1;
    txv[1] = 1'b1;
    txd[1] = 8'h3C;
    @(negedge clk_sys);
    go = 1'b0;
    txv[1] = 1'b0;
    // first two data bits of the looped char are zero, so a leak shows
    repeat (256) @(negedge clk_sys);
    check(tx_pins[1], 1'b1, "looped pin moved");
    rx_expect(1, 8'h3C);
    lb[1] = 1'b0;
  endtask : t_loopback

  initial begin
    {en, lb, txv, rd, txd, go, sel, ch} = '0;
    do_reset();
    t_fill_block();
    do_reset();
    t_ext_receive();
    t_tx_frame();
    t_loopback();
    tally_and_finish();
  end

  // hang guard, about five times the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish();
  end
endmodule : quad_uart_serial_pins_ready_flags_tb_top

`default_nettype wire
